// file: design/baud_timing.sv
module baud_timing (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        low_speed_clock,
    input  wire logic        frame_start,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             oversample_tick,
    output logic             bit_end,
    output logic             frame_active
);
    import baud_pkg::*;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        FR_IDLE   = 3'b001,
        FR_ACTIVE = 3'b010,
        FR_STOP   = 3'b100
    } frame_e;

    typedef struct packed {
        baud_cfg_s  cfg;
        logic       aw_got;
        logic [3:0] aw_addr;
        logic       w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        frame_e     fstate;
        logic [4:0] tick_left;
        logic [3:0] bit_index;
        logic       odd_bit;
        logic       lsc_prev;
        logic       base_en;
        logic       tick;
        logic       bit_end;
        logic       awready;
        logic       wready;
        logic       arready;
        logic       active;
    } top_state_s;

    top_state_s st_r;
    top_state_s st_nxt;
    logic       div_tick;
    logic [3:0] frame_bits;
    logic [4:0] bit_ticks;

    // =========================================================
    // Tick divider
    tick_divider i_tick_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (st_r.cfg.enable),
        .base_en (st_r.base_en),
        .divisor (st_r.cfg.divisor),
        .tick    (div_tick)
    );

    // =========================================================
    // Bits per frame: start + data + optional parity + stops
    always_comb begin
        frame_bits = 4'h1 + FRAME_DATA_BITS + {3'h0, st_r.cfg.parity_enable}
                   + {3'h0, st_r.cfg.stop_bit_length} + 4'h1;
    end

    // Ticks for the bit starting now; start bit is even, takes shorter
    always_comb begin
        unique case (st_r.cfg.ticksel)
            TICKSEL_16_17: bit_ticks = st_r.odd_bit ? TICKS_17 : TICKS_16;
            TICKSEL_15:    bit_ticks = TICKS_15;
            TICKSEL_15_16: bit_ticks = st_r.odd_bit ? TICKS_16 : TICKS_15;
            TICKSEL_17:    bit_ticks = TICKS_17;
            default:       bit_ticks = TICKS_16;
        endcase
    end

    // =========================================================
    // Next-state logic: bus slave, base select, bit timing
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick    = div_tick;
        st_nxt.bit_end = 1'b0;
        st_nxt.lsc_prev = low_speed_clock;
        // Base clock: system clock or rising edges of low-speed clock
        st_nxt.base_en = st_r.cfg.base_sel ? (low_speed_clock & ~st_r.lsc_prev) : 1'b1;

        // Write address and data taken in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr[3:0];
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
            unique case (st_r.aw_addr)
                DIVISOR_OFFSET: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.cfg.divisor = st_r.w_data[7:0];
                    end
                end
                CONTROL_OFFSET: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.cfg.ticksel         = st_r.w_data[CTRL_TICKSEL_LSB +: 3];
                        st_nxt.cfg.base_sel        = st_r.w_data[CTRL_BASESEL_BIT];
                        st_nxt.cfg.parity_enable   = st_r.w_data[CTRL_PARITY_BIT];
                        st_nxt.cfg.parity_odd      = st_r.w_data[CTRL_ODD_BIT];
                        st_nxt.cfg.stop_bit_length = st_r.w_data[CTRL_STOP2_BIT];
                    end
                    if (st_r.w_strb[1]) begin
                        st_nxt.cfg.enable = st_r.w_data[CTRL_ENABLE_BIT];
                    end
                end
                STATUS_OFFSET: st_nxt.bresp = RESP_OKAY; // Read-only, write ignored
                default:       st_nxt.bresp = RESP_SLVERR;
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read: answer one cycle after address taken
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr[3:0])
                DIVISOR_OFFSET: st_nxt.rdata[7:0] = st_r.cfg.divisor;
                CONTROL_OFFSET: begin
                    st_nxt.rdata[CTRL_TICKSEL_LSB +: 3] = st_r.cfg.ticksel;
                    st_nxt.rdata[CTRL_BASESEL_BIT]      = st_r.cfg.base_sel;
                    st_nxt.rdata[CTRL_PARITY_BIT]       = st_r.cfg.parity_enable;
                    st_nxt.rdata[CTRL_ODD_BIT]          = st_r.cfg.parity_odd;
                    st_nxt.rdata[CTRL_STOP2_BIT]        = st_r.cfg.stop_bit_length;
                    st_nxt.rdata[CTRL_ENABLE_BIT]       = st_r.cfg.enable;
                end
                STATUS_OFFSET: begin
                    st_nxt.rdata[4:0]  = st_r.tick_left;
                    st_nxt.rdata[11:8] = st_r.bit_index;
                    st_nxt.rdata[16]   = (st_r.fstate != FR_IDLE);
                    // Receiver sample window, ticks 8 down to 6 of a bit
                    st_nxt.rdata[17]   = (st_r.fstate == FR_ACTIVE)
                                       && (st_r.tick_left <= SAMPLE_FIRST)
                                       && (st_r.tick_left >= SAMPLE_LAST);
                end
                default: st_nxt.rresp = RESP_SLVERR;
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // Frame bit timing, counted down per tick
        unique case (st_r.fstate)
            FR_IDLE: begin
                if (frame_start && st_r.cfg.enable) begin
                    st_nxt.fstate    = FR_ACTIVE;
                    st_nxt.bit_index = 4'h0;
                    st_nxt.odd_bit   = 1'b0;
                    st_nxt.tick_left = 5'h00;
                end
            end
            FR_ACTIVE: begin
                if (div_tick) begin
                    if (st_r.tick_left == 5'h00) begin
                        st_nxt.tick_left = bit_ticks - 5'h01;
                    end else if (st_r.tick_left == 5'h01) begin
                        st_nxt.tick_left = 5'h00;
                        st_nxt.bit_end   = 1'b1;
                        st_nxt.odd_bit   = ~st_r.odd_bit;
                        st_nxt.bit_index = st_r.bit_index + 4'h1;
                        if (st_r.bit_index + 4'h1 == frame_bits) begin
                            st_nxt.fstate = FR_STOP;
                        end
                    end else begin
                        st_nxt.tick_left = st_r.tick_left - 5'h01;
                    end
                end
            end
            FR_STOP: st_nxt.fstate = FR_IDLE;
            default: st_nxt.fstate = FR_IDLE;
        endcase
        if (!st_r.cfg.enable) begin
            st_nxt.fstate = FR_IDLE;
        end

        // Ready and active flags kept in flops, from the next state
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
        st_nxt.active  = (st_nxt.fstate == FR_ACTIVE);
    end

    // =========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r                 <= '0;
            st_r.cfg.divisor     <= DIVISOR_RESET;
            st_r.cfg.ticksel     <= TICKSEL_RESET;
            st_r.fstate          <= FR_IDLE;
            st_r.lsc_prev        <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // Outputs, all registered
    assign s_axi_awready   = st_r.awready;
    assign s_axi_wready    = st_r.wready;
    assign s_axi_bvalid    = st_r.bvalid;
    assign s_axi_bresp     = st_r.bresp;
    assign s_axi_arready   = st_r.arready;
    assign s_axi_rvalid    = st_r.rvalid;
    assign s_axi_rdata     = st_r.rdata;
    assign s_axi_rresp     = st_r.rresp;
    assign oversample_tick = st_r.tick;
    assign bit_end         = st_r.bit_end;
    assign frame_active    = st_r.active;
endmodule

// file: design/baud_pkg.sv
//
// Function
// - One oversample tick per (baud_divisor + 1) cycles of the selected base clock.
// - Each serial bit lasts 15 to 17 ticks, chosen by tick-count select.
// - Codes 001 and 011 alternate counts per bit, averaging 16.5 and 15.5 ticks.
// - 000=16, 001=16/17, 010=15, 011=15/16, 100=17; start bit takes shorter.
// - Baud equals base clock over average ticks times (divisor plus one).
// - Select 000 with divisor 0x19 gives bits of exactly 16 times 26 cycles.
// - Frame is start, eight data bits, optional parity, one or two stops.
// - Receiver counts ticks down from falling edge, majority of ticks 8 to 6.
package baud_pkg;

    // =========================================================
    // Register map (byte addresses)
    localparam logic [3:0] DIVISOR_OFFSET = 4'h0;
    localparam logic [3:0] CONTROL_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET  = 4'h8;

    // =========================================================
    // Control field positions and reset values
    localparam int CTRL_TICKSEL_LSB = 0;
    localparam int CTRL_BASESEL_BIT = 4;
    localparam int CTRL_PARITY_BIT  = 5;
    localparam int CTRL_ODD_BIT     = 6;
    localparam int CTRL_STOP2_BIT   = 7;
    localparam int CTRL_ENABLE_BIT  = 8;
    localparam logic [7:0] DIVISOR_RESET = 8'h00;
    localparam logic [2:0] TICKSEL_RESET = 3'h0;

    // =========================================================
    // Tick-count select codes and counts
    localparam logic [2:0] TICKSEL_16    = 3'h0;
    localparam logic [2:0] TICKSEL_16_17 = 3'h1;
    localparam logic [2:0] TICKSEL_15    = 3'h2;
    localparam logic [2:0] TICKSEL_15_16 = 3'h3;
    localparam logic [2:0] TICKSEL_17    = 3'h4;
    localparam logic [4:0] TICKS_15      = 5'h0F;
    localparam logic [4:0] TICKS_16      = 5'h10;
    localparam logic [4:0] TICKS_17      = 5'h11;
    localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
    localparam logic [4:0] SAMPLE_FIRST  = 5'h08;
    localparam logic [4:0] SAMPLE_LAST   = 5'h06;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] divisor;
        logic [2:0] ticksel;
        logic       base_sel;
        logic       parity_enable;
        logic       parity_odd;
        logic       stop_bit_length;
        logic       enable;
    } baud_cfg_s;

    typedef struct packed {
        logic       tick;
        logic       bit_end;
        logic       frame_start;
        logic [3:0] bit_index;
        logic [4:0] tick_count;
    } baud_stat_s;

endpackage

// file: design/tick_divider.sv
module tick_divider (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       enable,
    input  wire logic       base_en,
    input  wire logic [7:0] divisor,
    output logic            tick
);
    import baud_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } div_state_s;

    div_state_s st_r;
    div_state_s st_nxt;

    // Count base clock enables; pulse after divisor+1 of them
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!enable) begin
            st_nxt.cnt = 8'h00;
        end else if (base_en) begin
            if (st_r.cnt >= divisor) begin
                st_nxt.cnt  = 8'h00;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// file: test/serial_peer.sv
// ==========================================
// Far-side serial controller model
module serial_peer (
    input  wire logic aclk,
    input  wire logic go,
    output logic      frame_start,
    output logic      low_speed_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_r = 2'h0;
    // Slow base clock at a quarter of aclk
    always @(posedge aclk) div_r <= div_r + 2'h1;
    assign low_speed_clock = div_r[1];
    // One start mark per go pulse, sent by the peer a cycle later
    initial frame_start = 1'h0;
    always @(posedge aclk) frame_start <= go;
endmodule

// file: test/baud_timing_props.sv
// ==========================================
// Timing and bus checks at the block ports
module baud_timing_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        oversample_tick,
    input wire logic        bit_end,
    input wire logic        frame_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write and read requests taken
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_reset_quiet: assert property ($rose(aresetn) |-> !oversample_tick && !bit_end && !frame_active)
        else $error("timing outputs busy after reset");
    a_bit_gap: assert property (bit_end |=> (!bit_end)[*8])
        else $error("bit end pulses too close");
    a_bit_framed: assert property (bit_end |-> $past(frame_active))
        else $error("bit end outside a frame");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped or changed");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while response pending");
    a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response late");
endmodule

bind baud_timing baud_timing_props i_baud_timing_props (.*);

// file: test/tb_baud_timing.sv
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
// ==========================================
// Bench for the baud timing block
module tb_baud_timing;
    timeunit 1ns;
    timeprecision 1ns;
    import baud_pkg::*;
    typedef struct {logic [31:0] ctrl; logic [7:0] dv; int sc; int nb;} row_s;
    logic        aclk = 1'h0, aresetn = 1'h0, go = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        oversample_tick, bit_end, frame_active, frame_start, low_speed_clock;
    int          fail_count = 0, samples_checked = 0, cyc = 0;
    // Control, divisor, base scale, bits per frame
    row_s rows[7] = '{'{32'h100, 8'h19, 1, 10}, '{32'h121, 8'h02, 1, 11}, '{32'h182, 8'h02, 1, 11},
        '{32'h1E3, 8'h02, 1, 12}, '{32'h104, 8'h02, 1, 10}, '{32'h110, 8'h01, 4, 10},
        '{32'h107, 8'h02, 1, 10}};
    baud_timing i_baud_timing (.*);
    serial_peer i_serial_peer (.*);
    // Clock and cycle count
    always #25 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic fail_out();
        fail_count++;
        finish_test();
    endtask
    // Bus write, hold each channel until taken
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 50) fail_out();
        `CHK(s_axi_bresp, er)
    endtask
    // Bus read and compare
    task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (n == 50) fail_out();
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
    endtask
    // Bounded wait for a tick or a bit end
    task automatic wt(input bit sel, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(posedge aclk);
            if ((sel ? bit_end : oversample_tick) === 1'h1) return;
        end
        fail_out();
    endtask
    task automatic pulse();
        go <= 1'h1;
        @(posedge aclk);
        go <= 1'h0;
    endtask
    // Ticks in bit k of a frame
    function automatic int tk(logic [2:0] c, int k);
        case (c)
            3'h1: return k[0] ? 17 : 16;
            3'h2: return 15;
            3'h3: return k[0] ? 16 : 15;
            3'h4: return 17;
            default: return 16;
        endcase
    endfunction
    // Main sequence
    initial begin
        int t0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[i]) begin
            wr(DIVISOR_OFFSET, rows[i].dv, 2'h0);
            wr(CONTROL_OFFSET, rows[i].ctrl, 2'h0);
            rd(CONTROL_OFFSET, rows[i].ctrl, 2'h0);
            wt(0, 3000);
            t0 = cyc;
            wt(0, 3000);
            `CHK(cyc - t0, (rows[i].dv + 1) * rows[i].sc)
            pulse();
            for (int k = 0; k < rows[i].nb; k++) begin
                wt(1, 20000);
                if (k > 0) `CHK(cyc - t0, tk(rows[i].ctrl[2:0], k) * (rows[i].dv + 1) * rows[i].sc)
                t0 = cyc;
                // Mid-bit status: seventh tick left of the second data bit
                if (i == 0 && k == 1) begin
                    repeat (244) @(posedge aclk);
                    rd(STATUS_OFFSET, 32'h0003_0207, 2'h0);
                end
                if (k == 3) pulse();
            end
            repeat (3) @(posedge aclk);
            `CHK(frame_active, 1'h0)
            rd(STATUS_OFFSET, rows[i].nb << 8, 2'h0);
        end
        // Widest divisor, unmapped place
        wr(DIVISOR_OFFSET, 32'hFF, 2'h0);
        rd(DIVISOR_OFFSET, 32'hFF, 2'h0);
        wt(0, 600);
        t0 = cyc;
        wt(0, 600);
        `CHK(cyc - t0, 256)
        rd(32'hC, 32'h0, 2'h2);
        wr(32'hC, 32'h0, 2'h2);
        // Reset in mid-frame, then start while disabled
        pulse();
        repeat (40) @(posedge aclk);
        `CHK(frame_active, 1'h1)
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        `CHK(frame_active, 1'h0)
        rd(DIVISOR_OFFSET, {24'h0, DIVISOR_RESET}, 2'h0);
        rd(CONTROL_OFFSET, 32'h0, 2'h0);
        pulse();
        repeat (4) @(posedge aclk);
        `CHK(frame_active, 1'h0)
        finish_test();
    end
endmodule
